// *** sideband_pkg.sv ***
// Constants, types and the byte map shared by the sideband control block.
// Assumes a single 100 MHz clock; all pin inputs already synchronous to it.
package sideband_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RESET_MIN_NS     = 10000;  // Minimum reset pulse on the pin
  localparam int unsigned RESET_MIN_CYC    = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned INIT_NS          = 2000;   // Internal settle time after reset
  localparam int unsigned INIT_CYC         = (INIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W            = 11;

  // 2-wire slave address, arbitrary default
  localparam logic [6:0]  DEV_ADDR         = 7'h50;

  // 2-wire byte map
  localparam logic [7:0]  MAP_STATUS       = 8'h00;
  localparam logic [7:0]  MAP_FLAGS        = 8'h01;
  localparam logic [7:0]  MAP_CONTROL      = 8'h02;
  localparam logic [7:0]  MAP_MASK         = 8'h03;
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam int unsigned FLAG_RESET_DONE  = 0;
  localparam int unsigned CTRL_FORCE_LP    = 0;

  // Avalon register byte offsets
  localparam logic [3:0]  REG_STATUS       = 4'h0;
  localparam logic [3:0]  REG_IRQ_STAT     = 4'h4;
  localparam logic [3:0]  REG_IRQ_MASK     = 4'h8;
  localparam logic [3:0]  REG_FAULT_SET    = 4'hc;
  localparam logic [3:0]  IRQ_RESET        = 4'h0;

  // Avalon event bits
  localparam int unsigned EV_RESET_DONE    = 0;
  localparam int unsigned EV_PIN_RESET     = 1;
  localparam int unsigned EV_HOST_WRITE    = 2;
  localparam int unsigned EV_ALERT_CLEAR   = 3;

  // Sampled pin with its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_evt_t;

  typedef enum logic [1:0] {MOD_RUN, MOD_RESET, MOD_INIT} mod_state_t;
  typedef enum logic [2:0] {TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_WDATA, TW_WACK,
                            TW_RDATA, TW_RACK} tw_state_t;

  // Any flag left unmasked
  function automatic logic pending(input logic [7:0] flags, input logic [7:0] mask);
    pending = |(flags & ~mask);
  endfunction : pending

endpackage : sideband_pkg

// *** line_sampler.sv ***
// Registers one pin and reports its level with rise and fall pulses.
// Assumes the pin is already synchronous to mclk_i.
`timescale 1ns/100ps
module line_sampler
  import sideband_pkg::*;
(
  input  wire logic     mclk_i,
  input  wire logic     reset_n_i,
  input  wire logic     pin_i,
  output pin_evt_t      evt_o
);

  logic level_q;
  logic prev_q;

  // Idle level of both 2-wire lines is high
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      level_q <= 1'b1;
      prev_q  <= 1'b1;
    end
    else
    begin
      level_q <= pin_i;
      prev_q  <= level_q;
    end
  end

  assign evt_o.level = level_q;
  assign evt_o.rise  = level_q & ~prev_q;
  assign evt_o.fall  = ~level_q & prev_q;

endmodule : line_sampler

// *** pulse_qualifier.sv ***
// Qualifies an active-low pin: asserts once it has been low long enough.
// Assumes a synchronous pin; glitches shorter than the minimum are dropped.
`timescale 1ns/100ps
module pulse_qualifier
  import sideband_pkg::*;
(
  input  wire logic     mclk_i,
  input  wire logic     reset_n_i,
  input  wire logic     pin_n_i,
  output logic          held_o
);

  logic [CNT_W-1:0] low_cnt_q;

  // Count low cycles, saturate at the minimum width
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      low_cnt_q <= '0;
      held_o    <= 1'b0;
    end
    else if (pin_n_i)
    begin
      low_cnt_q <= '0;
      held_o    <= 1'b0;
    end
    else if (low_cnt_q < CNT_W'(RESET_MIN_CYC))
      low_cnt_q <= low_cnt_q + 1'b1;
    else
      held_o    <= 1'b1;
  end

endmodule : pulse_qualifier

// *** sideband_ctrl.sv ***
// Sideband control of a pluggable cable module: select-gated 2-wire slave,
// reset pin handling, open-drain alert, presence and low-power control.
// Assumes synchronous pins, a host-side pull-up on the alert and SDA lines
// and an Avalon-MM master on the local side.
//
// Contract
// - Answer 2-wire commands only while selected low
// - Deselected: ignore bus, never drive SDA
// - Undriven select reads as deselected high
// - Long reset pulse restores settable state defaults
// - Reset completion raises an interrupt flag
// - Alert is open-drain, low on attention
// - Presence output tied low inside module
`timescale 1ns/100ps
module sideband_ctrl
  import sideband_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Edge connector pins
  input  wire logic        bus_select_n_i,
  input  wire logic        module_reset_n_i,
  input  wire logic        low_power_request_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             attention_alert_n_o,
  output logic             attention_alert_n_oe_o,
  output logic             presence_detect_n_o,
  output logic             low_power_active_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o
);

  pin_evt_t   scl;
  pin_evt_t   sda;
  logic       pin_reset;
  logic       selected;
  mod_state_t mod_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic       reset_done;
  logic       busy;
  tw_state_t  tw_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] out_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       first_q;
  logic       nack_q;
  logic       drive_q;
  logic [7:0] flags_q;
  logic [7:0] control_q;
  logic [7:0] mask_q;
  logic       start_ev;
  logic       stop_ev;
  logic       tw_write;
  logic       flags_read;
  logic [7:0] rd_byte;
  logic [7:0] fault_set;
  logic       alert;
  logic       alert_q;
  logic       ack_q;
  logic       bus_req;
  logic       bus_done;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_set;

  line_sampler u_scl (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (scl_i),
    .evt_o     (scl)
  );

  line_sampler u_sda (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (sda_i),
    .evt_o     (sda)
  );

  pulse_qualifier u_rst (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pin_n_i   (module_reset_n_i),
    .held_o    (pin_reset)
  );

  // A floating select sits high on its pull-up, so only a firm low selects
  assign selected = (bus_select_n_i == 1'b0);

  // Module reset sequence; power-up after insertion also runs the init phase
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mod_q      <= MOD_INIT;
      init_cnt_q <= '0;
    end
    else
    begin
      case (mod_q)
        MOD_RUN:
        begin
          if (pin_reset)
            mod_q <= MOD_RESET;
        end
        MOD_RESET:
        begin
          init_cnt_q <= '0;
          if (!pin_reset)
            mod_q <= MOD_INIT;
        end
        MOD_INIT:
        begin
          if (pin_reset)
            mod_q <= MOD_RESET;
          else if (init_cnt_q >= CNT_W'(INIT_CYC))
            mod_q <= MOD_RUN;
          else
            init_cnt_q <= init_cnt_q + 1'b1;
        end
        default:
          mod_q <= MOD_INIT;
      endcase
    end
  end

  assign busy       = (mod_q != MOD_RUN);
  assign reset_done = (mod_q == MOD_INIT) && !pin_reset && (init_cnt_q >= CNT_W'(INIT_CYC));

  // A start only counts while SCL is high and the module is selected; a stop needs only SCL high
  assign start_ev = selected && scl.level && sda.fall;
  assign stop_ev  = scl.level && sda.rise;

  // Byte presented to the host on a read
  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_q == MAP_STATUS)
      rd_byte = {5'h00, low_power_active_o, alert, busy};
    else if (ptr_q == MAP_FLAGS)
      rd_byte = flags_q;
    else if (ptr_q == MAP_CONTROL)
      rd_byte = control_q;
    else if (ptr_q == MAP_MASK)
      rd_byte = mask_q;
  end

  // 2-wire slave: sample on SCL rise, change drive on SCL fall
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tw_q      <= TW_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      out_q     <= 8'hff;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      nack_q    <= 1'b0;
    end
    else if (!selected || busy || stop_ev)
      tw_q <= TW_IDLE;
    else if (start_ev)
    begin
      tw_q      <= TW_ADDR;
      bit_cnt_q <= 4'h0;
    end
    else if (scl.rise)
    begin
      if (tw_q == TW_ADDR || tw_q == TW_WDATA)
      begin
        shift_q   <= {shift_q[6:0], sda.level};
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
      else if (tw_q == TW_RACK)
        nack_q <= sda.level;
    end
    else if (scl.fall)
    begin
      case (tw_q)
        TW_ADDR:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            rw_q <= shift_q[0];
            tw_q <= (shift_q[7:1] == DEV_ADDR) ? TW_ADDR_ACK : TW_IDLE;
          end
        end
        TW_ADDR_ACK:
        begin
          bit_cnt_q <= 4'h0;
          first_q   <= 1'b1;
          out_q     <= rd_byte;
          tw_q      <= rw_q ? TW_RDATA : TW_WDATA;
        end
        TW_WDATA:
        begin
          if (bit_cnt_q == 4'h8)
          begin
            first_q <= 1'b0;
            tw_q    <= TW_WACK;
          end
        end
        TW_WACK:
        begin
          bit_cnt_q <= 4'h0;
          tw_q      <= TW_WDATA;
        end
        TW_RDATA:
        begin
          out_q     <= {out_q[6:0], 1'b1};
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == 4'h7)
            tw_q <= TW_RACK;
        end
        TW_RACK:
        begin
          bit_cnt_q <= 4'h0;
          out_q     <= rd_byte;
          tw_q      <= nack_q ? TW_IDLE : TW_RDATA;
        end
        default:
          tw_q <= TW_IDLE;
      endcase
    end
  end

  // Write and read side effects of the 2-wire engine
  assign tw_write   = selected && !busy && !stop_ev && !start_ev && scl.fall
                      && (tw_q == TW_WDATA) && (bit_cnt_q == 4'h8);
  assign flags_read = selected && !busy && !stop_ev && !start_ev && scl.fall
                      && (ptr_q == MAP_FLAGS)
                      && ((tw_q == TW_ADDR_ACK && rw_q) || (tw_q == TW_RACK && !nack_q));

  // Address pointer: first written byte loads it, every data byte advances it
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ptr_q <= 8'h00;
    else if (busy)
      ptr_q <= 8'h00;
    else if (tw_write)
      ptr_q <= first_q ? shift_q : ptr_q + 1'b1;
    else if (flags_read || (selected && scl.fall && !start_ev && !stop_ev
             && ((tw_q == TW_ADDR_ACK && rw_q) || (tw_q == TW_RACK && !nack_q))))
      ptr_q <= ptr_q + 1'b1;
  end

  // Host-settable bytes return to defaults on any module reset
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      control_q <= CONTROL_RESET;
      mask_q    <= MASK_RESET;
    end
    else if (mod_q == MOD_RESET)
    begin
      control_q <= CONTROL_RESET;
      mask_q    <= MASK_RESET;
    end
    else if (tw_write && !first_q)
    begin
      if (ptr_q == MAP_CONTROL)
        control_q <= shift_q;
      else if (ptr_q == MAP_MASK)
        mask_q <= shift_q;
    end
  end

  // Sticky flags: set wins over the clear of a read
  assign fault_set = (avs_write_i && ack_q && avs_address_i == REG_FAULT_SET
                      && avs_byteenable_i[0]) ? avs_writedata_i[7:0] : 8'h00;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flags_q <= 8'h00;
    else
    begin
      flags_q <= ((flags_read ? 8'h00 : flags_q) | fault_set);
      if (reset_done)
        flags_q[FLAG_RESET_DONE] <= 1'b1;
    end
  end

  // Open-drain alert: only ever pulls low, the host pull-up raises it
  assign alert = pending(flags_q, mask_q);

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alert_q <= 1'b0;
    else
      alert_q <= alert;
  end

  assign attention_alert_n_o    = 1'b0;
  assign attention_alert_n_oe_o = alert_q;

  // SDA pulled low for an ack or a zero data bit, released otherwise
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      drive_q <= 1'b0;
    else
      drive_q <= (tw_q == TW_ADDR_ACK) || (tw_q == TW_WACK)
                 || (tw_q == TW_RDATA && !out_q[7]);
  end

  // Deselect cuts the drive at once, not a cycle later
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_q && selected && !busy;

  // Presence is a ground strap
  assign presence_detect_n_o = 1'b0;

  // Low power held by the pin, a host override, or an unfinished reset
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      low_power_active_o <= 1'b1;
    else
      low_power_active_o <= low_power_request_i || control_q[CTRL_FORCE_LP] || busy;
  end

  // Avalon: one wait cycle, answer at the second edge of the request
  assign bus_req           = avs_read_i || avs_write_i;
  assign bus_done          = bus_req && ack_q;
  assign avs_waitrequest_o = bus_req && !ack_q;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req && !ack_q;
      if (avs_read_i && !ack_q)
      begin
        if (avs_address_i == REG_STATUS)
          avs_readdata_o <= {24'h00_0000, tw_q != TW_IDLE, selected,
                             low_power_active_o, alert_q, 2'(mod_q), busy, reset_done};
        else if (avs_address_i == REG_IRQ_STAT)
          avs_readdata_o <= {28'h000_0000, irq_stat_q};
        else if (avs_address_i == REG_IRQ_MASK)
          avs_readdata_o <= {28'h000_0000, irq_mask_q};
        else if (avs_address_i == REG_FAULT_SET)
          avs_readdata_o <= {24'h00_0000, flags_q};
        else
          avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // Local events; alert release is seen as the alert falling away
  assign irq_set = {alert_q && !alert, tw_write && !first_q, pin_reset && mod_q == MOD_RUN,
                    reset_done};

  // Sticky status, read-to-clear, new events win
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end
    else
    begin
      if (bus_done && avs_read_i && avs_address_i == REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~avs_readdata_o[3:0]) | irq_set;  // Unreported bits kept
      else
        irq_stat_q <= irq_stat_q | irq_set;
      if (bus_done && avs_write_i && avs_address_i == REG_IRQ_MASK && avs_byteenable_i[0])
        irq_mask_q <= avs_writedata_i[3:0];
    end
  end

  // Mask bit set enables the source
  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule : sideband_ctrl

// *** sideband_ctrl_monitor.sv ***
// Checker for the sideband control block, bound to its top module.
// Assumes the module reset pin stays high around a reset_n_i release.
`timescale 1ns/100ps
module sideband_ctrl_monitor
  import sideband_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic bus_select_n_i,
  input wire logic low_power_request_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic sda_oe_o,
  input wire logic attention_alert_n_o,
  input wire logic attention_alert_n_oe_o,
  input wire logic presence_detect_n_o,
  input wire logic low_power_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // Pin-level guarantees
  chk_presence_tied: assert property (presence_detect_n_o == 1'b0)
    else $error("presence output not low");
  chk_alert_opendrain: assert property (attention_alert_n_o == 1'b0)
    else $error("alert drives a high level");
  chk_sda_deselect: assert property (bus_select_n_i |-> !sda_oe_o)
    else $error("data line driven while deselected");
  // Init phase after release: no drive, low power, no alert
  chk_init_quiet: assert property ($rose(reset_n_i) |-> !sda_oe_o [*8])
    else $error("data line driven during init");
  chk_init_lowpower: assert property ($rose(reset_n_i) |-> low_power_active_o [*8])
    else $error("low power dropped during init");
  chk_alert_idle: assert property ($rose(reset_n_i) |-> !attention_alert_n_oe_o [*8])
    else $error("alert pulled with nothing pending");
  // Reset-done flag reaches the alert pin after the init time
  chk_reset_done: assert property ($rose(reset_n_i) |-> ##[195:215] attention_alert_n_oe_o)
    else $error("no alert after reset completion");
  chk_lp_request: assert property (low_power_request_i [*6] |-> low_power_active_o)
    else $error("low power not entered on request");
  // Exactly one wait cycle per access
  chk_wait_one: assert property ($rose(avs_read_i || avs_write_i)
                                 |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("register access not answered after one wait");

  cover property ($fell(attention_alert_n_oe_o));
  cover property (sda_oe_o);
  cover property ($rose(low_power_active_o));
endmodule : sideband_ctrl_monitor

bind sideband_ctrl sideband_ctrl_monitor i_mon (
  .mclk_i                 (mclk_i),
  .reset_n_i              (reset_n_i),
  .bus_select_n_i         (bus_select_n_i),
  .low_power_request_i    (low_power_request_i),
  .avs_read_i             (avs_read_i),
  .avs_write_i            (avs_write_i),
  .avs_waitrequest_o      (avs_waitrequest_o),
  .sda_oe_o               (sda_oe_o),
  .attention_alert_n_o    (attention_alert_n_o),
  .attention_alert_n_oe_o (attention_alert_n_oe_o),
  .presence_detect_n_o    (presence_detect_n_o),
  .low_power_active_o     (low_power_active_o)
);

// *** tw_host_model.sv ***
// Host management controller model: 2-wire master and module select.
// Assumes pull-ups on every line, resolved by the bench.
`timescale 1ns/100ps
module tw_host_model
  import sideband_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_oe_o,
  output logic      sda_oe_o,
  output logic      select_oe_o
);
  int half = 6;  // SCL half period in clocks; raise for a slow host

  // All lines released at start
  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    select_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // One module at a time: the bench never selects two
  task automatic select(input logic on);
    select_oe_o <= on;
    tick(2);
  endtask : select

  // Data moves only while SCL is low, a margin after its fall
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_oe_o <= !b;
    tick(half);
    scl_oe_o <= 1'b0;
    tick(half);
    r = sda_i;
    scl_oe_o <= 1'b1;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack = !r;
  endtask : byte_io

  task automatic start;
    sda_oe_o <= 1'b1;
    tick(half);
    scl_oe_o <= 1'b1;
  endtask : start

  // SCL released, then SDA rises: bus idle again
  task automatic stop;
    tick(2);
    sda_oe_o <= 1'b1;
    tick(half);
    scl_oe_o <= 1'b0;
    tick(half);
    sda_oe_o <= 1'b0;
    tick(half);
  endtask : stop

  // Pointer write, then either one data byte or a one-byte read ended by NACK
  task automatic tw_access(input logic wr, input logic [7:0] ptr, input logic [7:0] wd,
                           output logic [7:0] rd, output logic ok);
    logic a0, a1, a2;
    logic [7:0] q;
    rd = 8'h00;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    byte_io(ptr, 1'b1, q, a1);
    if (wr)
      byte_io(wd, 1'b1, q, a2);
    else
    begin
      stop();
      start();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a2);
      byte_io(8'hff, 1'b1, rd, q[0]);
    end
    stop();
    ok = a0 & a1 & a2;
  endtask : tw_access
endmodule : tw_host_model

// *** sideband_ctrl_bench.sv ***
// Self-checking bench for the sideband control block with a host model.
// Assumes the package map and an Avalon slave that may stall any access.
`timescale 1ns/100ps
module sideband_ctrl_bench;
  import sideband_pkg::*;
  logic        mclk_i, reset_n_i, module_reset_n_i, low_power_request_i;
  logic        avs_read_i, avs_write_i, ok;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdv, f;
  logic [7:0]  tb;
  logic        avs_waitrequest_o, irq_o, sda_o, sda_oe_o, alert_od, alert_oe;
  logic        presence_detect_n_o, low_power_active_o, scl_oe, hsda_oe, sel_oe;
  int          error_cnt, n_checks;
  wire         scl = !scl_oe;
  wire         sda = !(hsda_oe | sda_oe_o);
  wire         alert_line = !alert_oe;
  wire         sel_n = sel_oe ? 1'b0 : 1'b1;

  sideband_ctrl i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_select_n_i(sel_n),
    .module_reset_n_i(module_reset_n_i), .low_power_request_i(low_power_request_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .attention_alert_n_o(alert_od), .attention_alert_n_oe_o(alert_oe),
    .presence_detect_n_o(presence_detect_n_o), .low_power_active_o(low_power_active_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
  tw_host_model i_host (.mclk_i(mclk_i), .sda_i(sda), .scl_oe_o(scl_oe),
    .sda_oe_o(hsda_oe), .select_oe_o(sel_oe));

  // Free-running 100 MHz clock
  always #5 mclk_i = ~mclk_i;

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  // Pins are compared mid-cycle, clear of the edge updates
  task automatic chk_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : wait_cyc

  // Request held until waitrequest is seen low at a rising edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                    input logic [3:0] be);
    int n;
    logic w;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
    begin
      @(posedge mclk_i);
      n++;
      w = avs_waitrequest_o;
      rdv = avs_readdata_o;
    end
    while (w !== 1'b0 && n < 20);
    if (w !== 1'b0)
    begin
      chk_pin(w, 1'b0);
      stop_test();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : av

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    chk_pin(1'b1, 1'b0);
    stop_test();
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    {mclk_i, reset_n_i, low_power_request_i, avs_read_i, avs_write_i} = '0;
    {avs_address_i, avs_byteenable_i, avs_writedata_i} = '0;
    module_reset_n_i = 1'b1;
    void'($urandom(68));
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wait_cyc(INIT_CYC + 20);
    chk_pin(alert_line, 1'b0);
    chk_pin(presence_detect_n_o, 1'b0);
    @(posedge mclk_i);
    av(0, REG_IRQ_STAT, 0, 4'hf);
    chk_val(rdv, 32'h1);
    av(0, REG_IRQ_STAT, 0, 4'hf);
    chk_val(rdv, 32'h0);
    av(0, REG_STATUS, 0, 4'hf);
    chk_val(rdv & 32'h3e, 32'h10);
    av(1, REG_IRQ_MASK, 32'h8, 4'h1);
    // Deselected read gets no ACK; selected read finds the source
    i_host.tw_access(0, MAP_FLAGS, 0, tb, ok);
    chk_val({31'h0, ok}, 32'h0);
    i_host.select(1);
    i_host.tw_access(0, MAP_FLAGS, 0, tb, ok);
    chk_val({23'h0, ok, tb}, 32'h101);
    i_host.select(0);
    wait_cyc(4);
    chk_pin(alert_line, 1'b1);
    chk_pin(irq_o, 1'b1);
    @(posedge mclk_i);
    av(0, REG_IRQ_STAT, 0, 4'hf);
    chk_val(rdv, 32'h8);
    // Random fault flags, lane 0 disabled on the first pass
    for (int i = 0; i < 4; i++)
    begin
      f = $urandom_range(255, 1);
      i_host.half = $urandom_range(12, 4);
      av(1, REG_FAULT_SET, f, (i == 0) ? 4'h0 : (4'($urandom_range(15, 0)) | 4'h1));
      f = (i == 0) ? 32'h0 : f;
      wait_cyc(3);
      chk_pin(alert_line, f == 0);
      @(posedge mclk_i);
      av(0, REG_FAULT_SET, 0, 4'hf);
      chk_val(rdv, f);
      i_host.select(1);
      i_host.tw_access(0, MAP_FLAGS, 0, tb, ok);
      chk_val({24'h0, tb}, f);
      i_host.select(0);
      wait_cyc(3);
      chk_pin(alert_line, 1'b1);
      @(posedge mclk_i);
    end
    av(0, REG_IRQ_STAT, 0, 4'hf);
    // Low-power pin, then forced by control only when selected
    low_power_request_i <= 1'b1;
    wait_cyc(8);
    chk_pin(low_power_active_o, 1'b1);
    @(posedge mclk_i);
    // Random pin levels; registered output follows one cycle later
    repeat (4)
    begin
      low_power_request_i <= 1'($urandom_range(1, 0));
      wait_cyc(8);
      chk_pin(low_power_active_o, low_power_request_i);
      @(posedge mclk_i);
    end
    low_power_request_i <= 1'b0;
    wait_cyc(8);
    chk_pin(low_power_active_o, 1'b0);
    @(posedge mclk_i);
    i_host.tw_access(1, MAP_CONTROL, 8'h01, tb, ok);
    wait_cyc(4);
    chk_pin(low_power_active_o, 1'b0);
    @(posedge mclk_i);
    i_host.select(1);
    i_host.tw_access(1, MAP_CONTROL, 8'h01, tb, ok);
    i_host.select(0);
    wait_cyc(4);
    chk_pin(low_power_active_o, 1'b1);
    chk_pin(irq_o, 1'b0);
    @(posedge mclk_i);
    // Short pulse is ignored, a long one restores defaults
    module_reset_n_i <= 1'b0;
    repeat (RESET_MIN_CYC / 2) @(posedge mclk_i);
    module_reset_n_i <= 1'b1;
    wait_cyc(20);
    chk_pin(low_power_active_o, 1'b1);
    @(posedge mclk_i);
    av(0, REG_IRQ_STAT, 0, 4'hf);
    module_reset_n_i <= 1'b0;
    repeat (RESET_MIN_CYC + 10) @(posedge mclk_i);
    module_reset_n_i <= 1'b1;
    wait_cyc(INIT_CYC + 20);
    chk_pin(low_power_active_o, 1'b0);
    @(posedge mclk_i);
    av(0, REG_IRQ_STAT, 0, 4'hf);
    chk_val(rdv & 32'h3, 32'h3);
    stop_test();
  end
endmodule : sideband_ctrl_bench
